// ===== design/cmpdc_comparator_ctrl.sv
// Digital control around one analog comparator, reached over AXI4-Lite
//
// Functional notes
// - Raw result is low when plus input below minus input, high when above.
// - comparator_on enables the comparator; cleared means disabled, lowest power.
// - Result readable as result_bit and as mirrored_result.
// - Pin driven only with pin_output_enable, pin direction output, comparator_on.
// - pin_output_enable overrides the port latch regardless of comparator_on.
// - Internal result captured each cycle; pin path unregistered unless synced.
// - invert_output flips result_bit relative to raw compare.
// - speed_select resets to one (normal); zero selects low power.
// - hysteresis_enable adds hysteresis to comparator inputs.
// - With timer_sync_enable, result captured on gate timer clock falling edge.
// - Capture uses post-prescaler timer clock; timer counts on rising edges.
// - Result offered to gate timer as a gate source.
// - Rising and falling detectors set compare_irq_flag when enabled.
// - Flag cleared only by software write; concurrent edge keeps it set.
// - plus_input_select picks pin, DAC, fixed reference or ground.
// - minus_input_select picks one of four pins.
// - With comparator_on zero all input connections disabled.
// - Toggling invert_output or comparator_on while off can raise the flag.
// - Result available to capture/PWM auto-shutdown logic.
`timescale 1ns/10ps
module cmpdc_comparator_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Analog core
  input wire logic cmpRaw,
  output logic analogEnable,
  output logic lowPowerMode,
  output logic hystEnable,
  output logic plusConnect,
  output logic [1:0] plusSelect,
  output logic minusConnect,
  output logic [1:0] minusSelect,
  // Gate timer, post-prescaler clock sampled as a level
  input wire logic timerClk,
  output logic gateSource,
  // Pin and shutdown
  input wire logic pinDirection,
  input wire logic portLatch,
  output logic pinOut,
  output logic pinOe,
  output logic shutdownSource,
  // Interrupt flag for the system interrupt logic
  output logic irqFlag,
  output logic irqRequest
);
  cmpdc_pkg::cmpdc_state_t s_q, s_d;
  logic polarised;
  logic riseDet, fallDet, setFlag, clrFlag, tclkFall, pathOut;
  logic wrCommit;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    merge = old;
    if (strb[0]) begin
      merge[7:0] = nw[7:0];
    end
  endfunction

  // True for the four register words only; reads and writes refuse the same addresses
  function automatic logic mapped(input logic [3:0] a);
    mapped = (a == cmpdc_pkg::ADDR_CTRL_A) || (a == cmpdc_pkg::ADDR_CTRL_B) ||
      (a == cmpdc_pkg::ADDR_MIRROR) || (a == cmpdc_pkg::ADDR_IRQ);
  endfunction

  function automatic logic [7:0] packA(input cmpdc_pkg::cmpdc_cfg_t c, input logic r);
    packA = 8'h00;
    packA[cmpdc_pkg::A_ON] = c.on;
    packA[cmpdc_pkg::A_RESULT] = r;
    packA[cmpdc_pkg::A_OE] = c.oe;
    packA[cmpdc_pkg::A_INV] = c.inv;
    packA[cmpdc_pkg::A_SPEED] = c.speed;
    packA[cmpdc_pkg::A_HYS] = c.hys;
    packA[cmpdc_pkg::A_SYNC] = c.sync;
  endfunction

  function automatic logic [7:0] packB(input cmpdc_pkg::cmpdc_cfg_t c);
    packB = 8'h00;
    packB[cmpdc_pkg::B_RISE] = c.riseEn;
    packB[cmpdc_pkg::B_FALL] = c.fallEn;
    packB[cmpdc_pkg::B_PLUS_LO +: 2] = c.plusSel;
    packB[cmpdc_pkg::B_MINUS_LO +: 2] = c.minusSel;
  endfunction

  // Disabled core reads low; polarity still applies so toggles give edges
  assign polarised = (s_q.cfg.on & s_q.rawCap) ^ s_q.cfg.inv;
  assign riseDet = s_q.result & ~s_q.resultPrev;
  assign fallDet = ~s_q.result & s_q.resultPrev;
  assign setFlag = (riseDet & s_q.cfg.riseEn) | (fallDet & s_q.cfg.fallEn);
  assign tclkFall = s_q.tclkPrev & ~timerClk;
  // Pin path stays combinational unless sync mode needs the latch
  assign pathOut = s_q.cfg.sync ? s_q.syncOut : polarised;

  assign awready = (s_q.bus == cmpdc_pkg::CMPDC_IDLE) && !s_q.awTaken;
  assign wready = (s_q.bus == cmpdc_pkg::CMPDC_IDLE) && !s_q.wTaken;
  assign arready = (s_q.bus == cmpdc_pkg::CMPDC_IDLE) && !s_q.awTaken && !s_q.wTaken;
  assign bvalid = s_q.bus == cmpdc_pkg::CMPDC_WRESP;
  assign rvalid = s_q.bus == cmpdc_pkg::CMPDC_RRESP;
  assign bresp = s_q.resp;
  assign rresp = s_q.resp;
  assign rdata = s_q.rData;

  assign analogEnable = s_q.cfg.on;
  assign lowPowerMode = ~s_q.cfg.speed;
  assign hystEnable = s_q.cfg.hys;
  assign plusConnect = s_q.cfg.on;
  assign minusConnect = s_q.cfg.on;
  assign plusSelect = s_q.cfg.plusSel;
  assign minusSelect = s_q.cfg.minusSel;
  assign gateSource = pathOut;
  assign shutdownSource = s_q.result;
  assign pinOe = s_q.cfg.oe & ~pinDirection & s_q.cfg.on;
  assign pinOut = s_q.cfg.oe ? pathOut : portLatch;
  assign irqFlag = s_q.irqFlag;
  assign irqRequest = s_q.irqFlag & s_q.cfg.irqEn;
  assign wrCommit = (s_q.bus == cmpdc_pkg::CMPDC_IDLE) && s_q.awTaken && s_q.wTaken;

  always_comb begin
    logic [31:0] wd;
    logic [3:0] wa;
    logic doWrite;
    wd = 32'h0;
    wa = 4'h0;
    doWrite = 1'b0;
    clrFlag = 1'b0;
    s_d = s_q;
    s_d.rawCap = cmpRaw;
    s_d.result = polarised;
    s_d.resultPrev = s_q.result;
    s_d.tclkPrev = timerClk;
    if (tclkFall) begin
      s_d.syncOut = polarised;
    end
    if (awvalid && awready) begin
      s_d.awTaken = 1'b1;
      s_d.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      s_d.wTaken = 1'b1;
      s_d.wData = wdata;
      s_d.wStrb = wstrb;
    end
    case (s_q.bus)
      cmpdc_pkg::CMPDC_IDLE: begin
        if (s_q.awTaken && s_q.wTaken) begin
          doWrite = 1'b1;
          wa = s_q.awAddr;
          wd = merge(32'h0, s_q.wData, s_q.wStrb);
          s_d.awTaken = 1'b0;
          s_d.wTaken = 1'b0;
          s_d.bus = cmpdc_pkg::CMPDC_WRESP;
          s_d.resp = cmpdc_pkg::RESP_OKAY;
          if (!mapped(wa)) begin
            s_d.resp = cmpdc_pkg::RESP_SLVERR;
          end
        end else if (arvalid && arready) begin
          s_d.bus = cmpdc_pkg::CMPDC_RRESP;
          s_d.resp = mapped(araddr) ? cmpdc_pkg::RESP_OKAY : cmpdc_pkg::RESP_SLVERR;
          // Stray low address bits are refused rather than aliased onto a register
          case (araddr)
            cmpdc_pkg::ADDR_CTRL_A: s_d.rData = {24'h0, packA(s_q.cfg, s_q.result)};
            cmpdc_pkg::ADDR_CTRL_B: s_d.rData = {24'h0, packB(s_q.cfg)};
            cmpdc_pkg::ADDR_MIRROR: s_d.rData = {31'h0, s_q.result};
            cmpdc_pkg::ADDR_IRQ: s_d.rData = {30'h0, s_q.cfg.irqEn, s_q.irqFlag};
            default: s_d.rData = 32'h0;
          endcase
        end
      end
      cmpdc_pkg::CMPDC_WRESP: begin
        if (bready) begin
          s_d.bus = cmpdc_pkg::CMPDC_IDLE;
        end
      end
      cmpdc_pkg::CMPDC_RRESP: begin
        if (rready) begin
          s_d.bus = cmpdc_pkg::CMPDC_IDLE;
        end
      end
      default: s_d.bus = cmpdc_pkg::CMPDC_IDLE;
    endcase
    if (doWrite && s_q.wStrb[0]) begin
      case (wa)
        cmpdc_pkg::ADDR_CTRL_A: begin
          s_d.cfg.on = wd[cmpdc_pkg::A_ON];
          s_d.cfg.oe = wd[cmpdc_pkg::A_OE];
          s_d.cfg.inv = wd[cmpdc_pkg::A_INV];
          s_d.cfg.speed = wd[cmpdc_pkg::A_SPEED];
          s_d.cfg.hys = wd[cmpdc_pkg::A_HYS];
          s_d.cfg.sync = wd[cmpdc_pkg::A_SYNC];
        end
        cmpdc_pkg::ADDR_CTRL_B: begin
          s_d.cfg.riseEn = wd[cmpdc_pkg::B_RISE];
          s_d.cfg.fallEn = wd[cmpdc_pkg::B_FALL];
          s_d.cfg.plusSel = wd[cmpdc_pkg::B_PLUS_LO +: 2];
          s_d.cfg.minusSel = wd[cmpdc_pkg::B_MINUS_LO +: 2];
        end
        cmpdc_pkg::ADDR_IRQ: begin
          s_d.cfg.irqEn = wd[cmpdc_pkg::I_EN];
          clrFlag = ~wd[cmpdc_pkg::I_FLAG];
        end
        default: ;
      endcase
    end
    // Writing zero clears the flag, but a same-cycle edge wins
    if (setFlag) begin
      s_d.irqFlag = 1'b1;
    end else if (clrFlag) begin
      s_d.irqFlag = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.bus <= cmpdc_pkg::CMPDC_IDLE;
      s_q.cfg.speed <= cmpdc_pkg::CTRL_A_RST[cmpdc_pkg::A_SPEED];
    end else begin
      s_q <= s_d;
    end
  end

  // Assertions
  property p_flag_set;
    @(posedge clk) disable iff (!nrst) setFlag |=> s_q.irqFlag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("edge did not set flag");

  property p_flag_hold;
    @(posedge clk) disable iff (!nrst) s_q.irqFlag && !(s_q.bus == cmpdc_pkg::CMPDC_IDLE && s_q.awTaken && s_q.wTaken)
      |=> s_q.irqFlag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag cleared without write");

  property p_pin_oe;
    @(posedge clk) disable iff (!nrst) pinOe |-> (s_q.cfg.on && s_q.cfg.oe && !pinDirection);
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin driven illegally");

  property p_capture;
    @(posedge clk) disable iff (!nrst) s_q.cfg.on && !s_q.cfg.inv && $stable(s_q.cfg.on) && $stable(s_q.cfg.inv)
      ##1 (s_q.cfg.on && !s_q.cfg.inv) |-> s_q.result == $past(s_q.rawCap);
  endproperty
  a_capture: assert property (p_capture) else $error("result not captured");

  property p_off_inputs;
    @(posedge clk) disable iff (!nrst) !s_q.cfg.on |-> !plusConnect && !minusConnect && !analogEnable;
  endproperty
  a_off_inputs: assert property (p_off_inputs) else $error("inputs connected while off");

  property p_mirror;
    @(posedge clk) disable iff (!nrst) shutdownSource == $past(polarised);
  endproperty
  a_mirror: assert property (p_mirror) else $error("shutdown source differs");

  property p_sync_hold;
    @(posedge clk) disable iff (!nrst) s_q.cfg.sync && !tclkFall ##1 s_q.cfg.sync |-> $stable(gateSource);
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("sync output moved off edge");

  property p_bypass;
    @(posedge clk) disable iff (!nrst) !s_q.cfg.sync |=> s_q.result == $past(gateSource);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass path wrong");

  property p_speed_reset;
    @(posedge clk) $rose(nrst) |-> s_q.cfg.speed;
  endproperty
  a_speed_reset: assert property (p_speed_reset) else $error("speed not normal after reset");

  property p_oe_override;
    @(posedge clk) disable iff (!nrst) !s_q.cfg.oe |-> pinOut == portLatch;
  endproperty
  a_oe_override: assert property (p_oe_override) else $error("port latch not passed to pin");

  property p_pin_data;
    @(posedge clk) disable iff (!nrst) s_q.cfg.oe && !s_q.cfg.sync |=> s_q.result == $past(pinOut);
  endproperty
  a_pin_data: assert property (p_pin_data) else $error("pin does not carry result");

  property p_pin_oe_on;
    @(posedge clk) disable iff (!nrst) s_q.cfg.oe && s_q.cfg.on && !pinDirection |-> pinOe;
  endproperty
  a_pin_oe_on: assert property (p_pin_oe_on) else $error("pin not driven when allowed");

  property p_polarity;
    @(posedge clk) disable iff (!nrst) $changed(s_q.cfg.inv) && $stable(s_q.cfg.on) && $stable(s_q.rawCap)
      |=> $changed(s_q.result);
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity change did not flip result");

  property p_rise_detect;
    @(posedge clk) disable iff (!nrst) $rose(s_q.result) && s_q.cfg.riseEn |=> s_q.irqFlag;
  endproperty
  a_rise_detect: assert property (p_rise_detect) else $error("rising edge missed");

  property p_fall_detect;
    @(posedge clk) disable iff (!nrst) $fell(s_q.result) && s_q.cfg.fallEn |=> s_q.irqFlag;
  endproperty
  a_fall_detect: assert property (p_fall_detect) else $error("falling edge missed");

  property p_no_spurious;
    @(posedge clk) disable iff (!nrst) !s_q.irqFlag && $stable(s_q.result) |=> !s_q.irqFlag;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("flag set without an edge");

  property p_off_result;
    @(posedge clk) disable iff (!nrst) !s_q.cfg.on |=> s_q.result == $past(s_q.cfg.inv);
  endproperty
  a_off_result: assert property (p_off_result) else $error("disabled result not polarity only");

  property p_sync_capture;
    @(posedge clk) disable iff (!nrst) s_q.cfg.sync && tclkFall ##1 s_q.cfg.sync |-> gateSource == $past(polarised);
  endproperty
  a_sync_capture: assert property (p_sync_capture) else $error("falling edge capture wrong");

  property p_rise_no_capture;
    @(posedge clk) disable iff (!nrst) !s_q.tclkPrev && timerClk |=> $stable(s_q.syncOut);
  endproperty
  a_rise_no_capture: assert property (p_rise_no_capture) else $error("capture on timer rising edge");

  property p_flag_clear;
    @(posedge clk) disable iff (!nrst) wrCommit && s_q.awAddr == cmpdc_pkg::ADDR_IRQ && s_q.wStrb[0]
      && !s_q.wData[cmpdc_pkg::I_FLAG] && !setFlag |=> !s_q.irqFlag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("software clear ignored");

  property p_read_mirror;
    @(posedge clk) disable iff (!nrst) arvalid && arready && araddr == cmpdc_pkg::ADDR_MIRROR
      |=> rvalid && rdata == {31'h0, $past(s_q.result)};
  endproperty
  a_read_mirror: assert property (p_read_mirror) else $error("mirror read wrong");

  property p_read_ctrl;
    @(posedge clk) disable iff (!nrst) arvalid && arready && araddr == cmpdc_pkg::ADDR_CTRL_A
      |=> rvalid && rdata[cmpdc_pkg::A_RESULT] == $past(s_q.result);
  endproperty
  a_read_ctrl: assert property (p_read_ctrl) else $error("result bit read wrong");

  property p_write_ctrl_a;
    @(posedge clk) disable iff (!nrst) wrCommit && s_q.awAddr == cmpdc_pkg::ADDR_CTRL_A && s_q.wStrb[0]
      |=> analogEnable == $past(s_q.wData[cmpdc_pkg::A_ON])
      && lowPowerMode == !$past(s_q.wData[cmpdc_pkg::A_SPEED])
      && hystEnable == $past(s_q.wData[cmpdc_pkg::A_HYS]);
  endproperty
  a_write_ctrl_a: assert property (p_write_ctrl_a) else $error("core controls not applied");

  property p_write_ctrl_b;
    @(posedge clk) disable iff (!nrst) wrCommit && s_q.awAddr == cmpdc_pkg::ADDR_CTRL_B && s_q.wStrb[0]
      |=> plusSelect == $past(s_q.wData[cmpdc_pkg::B_PLUS_LO +: 2])
      && minusSelect == $past(s_q.wData[cmpdc_pkg::B_MINUS_LO +: 2]);
  endproperty
  a_write_ctrl_b: assert property (p_write_ctrl_b) else $error("input selects not applied");
endmodule

// ===== design/cmpdc_pkg.sv
// Package: register map, field positions and shared types for the comparator control block
package cmpdc_pkg;
  // AXI4-Lite register byte addresses
  localparam logic [3:0] ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B = 4'h4;
  localparam logic [3:0] ADDR_MIRROR = 4'h8;
  localparam logic [3:0] ADDR_IRQ = 4'hC;
  // control_reg_a fields
  localparam int A_SYNC = 0;
  localparam int A_HYS = 1;
  localparam int A_SPEED = 2;
  localparam int A_INV = 4;
  localparam int A_OE = 5;
  localparam int A_RESULT = 6;
  localparam int A_ON = 7;
  // control_reg_b fields
  localparam int B_MINUS_LO = 0;
  localparam int B_PLUS_LO = 4;
  localparam int B_FALL = 6;
  localparam int B_RISE = 7;
  // irq register fields
  localparam int I_FLAG = 0;
  localparam int I_EN = 1;
  // Reset values and AXI response codes
  localparam logic [7:0] CTRL_A_RST = 8'h04;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CMPDC_IDLE = 3'b001,
    CMPDC_WRESP = 3'b010,
    CMPDC_RRESP = 3'b100
  } cmpdc_bus_t;

  typedef struct packed {
    logic on;
    logic oe;
    logic inv;
    logic speed;
    logic hys;
    logic sync;
    logic riseEn;
    logic fallEn;
    logic [1:0] plusSel;
    logic [1:0] minusSel;
    logic irqEn;
  } cmpdc_cfg_t;

  typedef struct packed {
    cmpdc_bus_t bus;
    logic awTaken;
    logic wTaken;
    logic [3:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic [31:0] rData;
    logic [1:0] resp;
    cmpdc_cfg_t cfg;
    logic rawCap;
    logic result;
    logic resultPrev;
    logic irqFlag;
    logic tclkPrev;
    logic syncOut;
  } cmpdc_state_t;
endpackage

// ===== sim/cmpdc_analog_model.sv
// Analog comparator core model driven by bench voltages
`timescale 1ns/10ps
module cmpdc_analog_model (
  // Clock
  input wire logic clk,
  // Controls from the block
  input wire logic analogEnable,
  input wire logic lowPowerMode,
  input wire logic hystEnable,
  input wire logic plusConnect,
  input wire logic [1:0] plusSelect,
  input wire logic minusConnect,
  input wire logic [1:0] minusSelect,
  // Source voltages in mV, 12 bits each, source 0 lowest
  input wire logic [47:0] vPlus,
  input wire logic [47:0] vMinus,
  // Raw result
  output logic cmpRaw
);
  logic [11:0] vp;
  logic [11:0] vm;
  logic fast;
  logic slow;
  assign vp = (plusSelect == 2'h3) ? 12'h000 : vPlus[plusSelect * 12 +: 12];
  assign vm = vMinus[minusSelect * 12 +: 12];
  // Hysteresis holds the old state inside a 16 mV band
  always @(posedge clk) begin
    if (!(analogEnable && plusConnect && minusConnect)) fast <= 1'b0;
    else if (!hystEnable || vp > vm + 12'h010 || vm > vp + 12'h010) fast <= vp > vm;
    slow <= fast;
  end
  // Low power answers a cycle later
  assign cmpRaw = lowPowerMode ? slow : fast;
endmodule

// ===== sim/cmpdc_comparator_ctrl_test.sv
// Self-checking bench for the comparator control block
`timescale 1ns/10ps
module cmpdc_comparator_ctrl_test;
  logic clk, nrst, awvalid, wvalid, bready, arvalid, rready, timerClk, pinDirection, portLatch;
  logic awready, wready, bvalid, arready, rvalid, cmpRaw, analogEnable, lowPowerMode, hystEnable;
  logic plusConnect, minusConnect, gateSource, pinOut, pinOe, shutdownSource, irqFlag, irqRequest;
  logic [1:0] bresp, rresp, plusSelect, minusSelect;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, seed;
  logic [47:0] vPlus, vMinus;
  logic [11:0] pv, mv;
  logic [16:0] tbl [7];
  logic [33:0] expR [$];
  logic [1:0] expB [$];
  logic res;
  int fails, checksDone, i;

  cmpdc_comparator_ctrl i_dut (.clk, .nrst, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
    .cmpRaw, .analogEnable, .lowPowerMode, .hystEnable, .plusConnect, .plusSelect, .minusConnect, .minusSelect,
    .timerClk, .gateSource, .pinDirection, .portLatch, .pinOut, .pinOe, .shutdownSource, .irqFlag, .irqRequest);
  cmpdc_analog_model i_core (.clk, .analogEnable, .lowPowerMode, .hystEnable, .plusConnect, .plusSelect,
    .minusConnect, .minusSelect, .vPlus, .vMinus, .cmpRaw);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic end_sim;
    if (fails == 0 && checksDone > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk_w(input string n, input logic [33:0] e, input logic [33:0] g);
    checksDone++;
    if (e !== g) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_b(input string n, input logic e, input logic g);
    chk_w(n, {33'h0, e}, {33'h0, g});
  endtask

  // Responses are matched in order against the oldest note
  always @(posedge clk) begin
    if (bvalid && bready)
      chk_w("bresp", {32'h0, expB.pop_front()}, {32'h0, bresp});
    if (rvalid && rready)
      chk_w("rdata", expR.pop_front(), {rresp, rdata});
  end

  task automatic tmo(input logic dn);
    if (!dn) begin
      fails++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic dn;
    dn = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    expB.push_back(cmpdc_pkg::RESP_OKAY);
    for (int n = 0; n < 50 && !dn; n++) begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        dn = 1'b1;
      end
    end
    tmo(dn);
  endtask

  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    logic dn;
    dn = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    expR.push_back(e);
    for (int n = 0; n < 50 && !dn; n++) begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        dn = 1'b1;
      end
    end
    tmo(dn);
  endtask

  // Software waits out the response interval before sampling
  task automatic settle;
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic tclk(input logic v);
    @(posedge clk);
    timerClk <= v;
    settle;
  endtask

  initial begin
    seed = 32'h5D92;
    {nrst, awvalid, wvalid, bready, arvalid, rready, timerClk, pinDirection, portLatch} = 9'h000;
    {awaddr, araddr, wdata} = 40'h0;
    wstrb = 4'hF;
    vPlus = 48'h000800100600;
    vMinus = 48'h700500200050;
    tbl = '{{8'h83, 8'h84, 1'b0}, {8'h80, 8'h84, 1'b1}, {8'h83, 8'h84, 1'b0}, {8'h43, 8'h84, 1'b0},
      {8'h40, 8'h84, 1'b0}, {8'h40, 8'h04, 1'b1}, {8'hC0, 8'h14, 1'b1}};
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rd(cmpdc_pkg::ADDR_CTRL_A, 34'h004);
    rd(cmpdc_pkg::ADDR_CTRL_B, 34'h000);
    rd(4'h2, {cmpdc_pkg::RESP_SLVERR, 32'h0});
    chk_b("lowPowerMode", 1'b0, lowPowerMode);
    // Every input pair, comparator off then on
    for (i = 0; i < 32; i++) begin
      wr(cmpdc_pkg::ADDR_CTRL_A, {i[4], 7'h02});
      wr(cmpdc_pkg::ADDR_CTRL_B, {2'h0, i[3:2], 2'h0, i[1:0]});
      pv = (i[3:2] == 2'h3) ? 12'h000 : vPlus[i[3:2] * 12 +: 12];
      mv = vMinus[i[1:0] * 12 +: 12];
      res = i[4] && pv > mv;
      settle;
      chk_b("plusConnect", i[4], plusConnect);
      chk_b("minusConnect", i[4], minusConnect);
      chk_b("analogEnable", i[4], analogEnable);
      chk_b("hystEnable", 1'b1, hystEnable);
      chk_b("lowPowerMode", 1'b1, lowPowerMode);
      chk_w("plusSelect", {32'h0, i[3:2]}, {32'h0, plusSelect});
      chk_w("minusSelect", {32'h0, i[1:0]}, {32'h0, minusSelect});
      rd(cmpdc_pkg::ADDR_CTRL_A, {26'h0, i[4], res, 6'h02});
      rd(cmpdc_pkg::ADDR_MIRROR, {33'h0, res});
    end
    // Polarity, pin override and internal consumers
    for (i = 0; i < 16; i++) begin
      seed = xs(seed);
      pinDirection <= seed[0];
      portLatch <= seed[1];
      wr(cmpdc_pkg::ADDR_CTRL_B, {6'h0, i[3], i[3]});
      wr(cmpdc_pkg::ADDR_CTRL_A, {i[2], 1'b0, i[1], i[0], 4'h4});
      res = (i[2] && !i[3]) ^ i[0];
      settle;
      rd(cmpdc_pkg::ADDR_CTRL_A, {26'h0, i[2], res, i[1], i[0], 4'h4});
      chk_b("pinOut", i[1] ? res : portLatch, pinOut);
      chk_b("pinOe", i[1] && !pinDirection && i[2], pinOe);
      chk_b("gateSource", res, gateSource);
      chk_b("shutdownSource", res, shutdownSource);
      chk_b("irqFlag", 1'b0, irqFlag);
    end
    // Timer-clock capture only on its falling edge
    wr(cmpdc_pkg::ADDR_CTRL_B, 8'h03);
    wr(cmpdc_pkg::ADDR_CTRL_A, 8'h85);
    tclk(1'b1);
    tclk(1'b0);
    wr(cmpdc_pkg::ADDR_CTRL_B, 8'h00);
    settle;
    chk_b("gateSource", 1'b0, gateSource);
    tclk(1'b1);
    chk_b("gateSource", 1'b0, gateSource);
    tclk(1'b0);
    chk_b("gateSource", 1'b1, gateSource);
    // Edge detectors, enables and software clearing
    wr(cmpdc_pkg::ADDR_CTRL_A, 8'h84);
    wr(cmpdc_pkg::ADDR_CTRL_B, 8'h03);
    wr(cmpdc_pkg::ADDR_IRQ, 8'h02);
    for (i = 0; i < 7; i++) begin
      wr(cmpdc_pkg::ADDR_CTRL_B, tbl[i][16:9]);
      wr(cmpdc_pkg::ADDR_CTRL_A, tbl[i][8:1]);
      settle;
      wr(cmpdc_pkg::ADDR_IRQ, 8'h03);
      rd(cmpdc_pkg::ADDR_IRQ, {32'h0, 1'b1, tbl[i][0]});
      chk_b("irqRequest", tbl[i][0], irqRequest);
      wr(cmpdc_pkg::ADDR_IRQ, 8'h02);
      rd(cmpdc_pkg::ADDR_IRQ, 34'h002);
    end
    end_sim();
  end
endmodule
